// ### hdl/shadow_data_port.sv
// UART shadow data port with its AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "shadow_port_defines.svh"

// Operation
// - Sixteen aliased words reach the same data
// - Read returns received byte in low bits
// - Read data valid only while data ready
// - No FIFO: new byte overwrites, flags overrun
// - FIFO on: read returns receive FIFO head
// - Full FIFO keeps contents, drops byte, overrun
// - Write queues low byte for serial output
// - No FIFO: one write clears holding empty
// - No FIFO: further write overwrites pending byte
// - FIFO on: sixteen bytes accepted before full
// - Write to full transmit FIFO is discarded
module shadow_data_port import shadow_port_pkg::*; (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        sin,
	input  wire logic        sir_in,
	output logic             sout,
	output logic             sir_out_n,
	output logic             irq
);

	// ****************************************
	// Declarations
	// ****************************************
	main_regs_t  st;
	main_regs_t  next_st;
	logic        addr_ok;
	reg_sel_t    rd_sel;
	reg_sel_t    wr_sel;
	logic        rx_line;
	logic        rx_done;
	logic [7:0]  rx_byte;
	logic        rx_in_valid;
	logic        rx_in_ready;
	logic        rx_pop;
	logic        rx_out_valid;
	logic [7:0]  rx_head;
	logic [4:0]  rx_count;
	logic        rx_flush;
	logic        tx_push;
	logic        tx_in_valid;
	logic        tx_in_ready;
	logic        tx_pop;
	logic        tx_out_valid;
	logic [7:0]  tx_head;
	logic [4:0]  tx_count;
	logic        tx_flush;
	logic        tx_start;
	logic [7:0]  tx_byte;
	logic        tx_busy;
	logic        tx_line;
	logic        data_ready;
	logic        tx_holding_empty;
	logic [2:0]  int_set;

	// ****************************************
	// Bus side
	// ****************************************
	// Zero wait states; every access is answered OKAY, unmapped reads give zero
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = st.hrdata;
	assign addr_ok   = hsel && hready && htrans[1];
	assign rd_sel    = reg_sel(haddr);
	assign wr_sel    = reg_sel(st.wr_addr);
	assign irq       = |(st.int_stat & st.int_mask);

	// Infrared input is taken as an active-high level meaning a zero bit
	assign rx_line   = st.ir_mode ? ~sir_in : sin;
	assign sout      = st.ir_mode ? 1'b1 : tx_line;
	assign sir_out_n = st.ir_mode ? tx_line : 1'b1;

	assign data_ready = st.fifo_en ? rx_out_valid : st.rx_hold_v;
	assign tx_holding_empty       = st.fifo_en ? (tx_count == 5'h00) : !st.tx_hold_v;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_st     = st;
		rx_done     = 1'b0;
		rx_byte     = st.rx_sh;
		rx_in_valid = 1'b0;
		rx_pop      = 1'b0;
		rx_flush    = 1'b0;
		tx_push     = 1'b0;
		tx_in_valid = 1'b0;
		tx_pop      = 1'b0;
		tx_flush    = 1'b0;
		tx_start    = 1'b0;
		tx_byte     = st.fifo_en ? tx_head : st.tx_hold;
		int_set     = 3'h0;

		// Receiver: start bit checked at mid-bit, data sampled one bit apart
		next_st.rx_cnt = st.rx_cnt + 16'h0001;
		case (st.rx_state)
			LINE_IDLE: begin
				next_st.rx_cnt = 16'h0000;
				if (!rx_line) begin
					next_st.rx_state = LINE_START;
				end
			end
			LINE_START: begin
				if (st.rx_cnt >= {1'b0, st.divisor[15:1]}) begin
					next_st.rx_cnt   = 16'h0000;
					next_st.rx_bit   = 3'h0;
					next_st.rx_state = rx_line ? LINE_IDLE : LINE_DATA;
				end
			end
			LINE_DATA: begin
				if (last_tick(st.rx_cnt, st.divisor)) begin
					next_st.rx_cnt = 16'h0000;
					next_st.rx_sh  = {rx_line, st.rx_sh[7:1]};
					next_st.rx_bit = st.rx_bit + 3'h1;
					if (st.rx_bit == 3'h7) begin
						next_st.rx_state = LINE_STOP;
					end
				end
			end
			default: begin
				if (last_tick(st.rx_cnt, st.divisor)) begin
					next_st.rx_cnt   = 16'h0000;
					next_st.rx_state = LINE_IDLE;
					rx_done          = 1'b1;
				end
			end
		endcase

		// Address phase of a read: data is latched now so it stands in the data phase
		next_st.wr_pend  = addr_ok && hwrite;
		next_st.wr_addr  = haddr;
		next_st.rd_alias = 1'b0;
		if (addr_ok && !hwrite) begin
			next_st.hrdata = 32'h0000_0000;
			if (rd_sel == SEL_ALIAS) begin
				next_st.rd_alias = 1'b1;
				next_st.hrdata[7:0] = st.fifo_en ? rx_head : st.rx_hold;
				rx_pop = st.fifo_en && rx_out_valid;
				if (!st.fifo_en) begin
					next_st.rx_hold_v = 1'b0;
				end
			end else if (rd_sel == SEL_FCR) begin
				next_st.hrdata[`FCR_EN_BIT] = st.fifo_en;
			end else if (rd_sel == SEL_LSR) begin
				next_st.hrdata[`LSR_DR_BIT]   = data_ready;
				next_st.hrdata[`LSR_OVR_BIT]  = st.ovr;
				next_st.hrdata[`LSR_TX_HOLDING_EMPTY_BIT] = tx_holding_empty;
				next_st.hrdata[`LSR_TEMT_BIT] = tx_holding_empty && !tx_busy;
				next_st.ovr = 1'b0;
			end else if (rd_sel == SEL_MODE) begin
				next_st.hrdata[`MODE_IR_BIT] = st.ir_mode;
			end else if (rd_sel == SEL_DIV) begin
				next_st.hrdata[15:0] = st.divisor;
			end else if (rd_sel == SEL_ISTAT) begin
				next_st.hrdata[2:0] = st.int_stat;
			end else if (rd_sel == SEL_IMASK) begin
				next_st.hrdata[2:0] = st.int_mask;
			end
		end

		// Data phase of a write; only the low byte of an alias write is used
		if (st.wr_pend) begin
			if (wr_sel == SEL_ALIAS) begin
				tx_push = 1'b1;
			end else if (wr_sel == SEL_FCR) begin
				next_st.fifo_en = hwdata[`FCR_EN_BIT];
				rx_flush = hwdata[`FCR_RXCLR_BIT] || (hwdata[`FCR_EN_BIT] != st.fifo_en);
				tx_flush = hwdata[`FCR_TXCLR_BIT] || (hwdata[`FCR_EN_BIT] != st.fifo_en);
			end else if (wr_sel == SEL_MODE) begin
				next_st.ir_mode = hwdata[`MODE_IR_BIT];
			end else if (wr_sel == SEL_DIV) begin
				next_st.divisor = hwdata[15:0];
			end else if (wr_sel == SEL_IMASK) begin
				next_st.int_mask = hwdata[2:0];
			end
		end

		// Received byte: FIFO when enabled, otherwise the single holding byte
		if (rx_done) begin
			int_set[`INT_RX_BIT] = 1'b1;
			if (st.fifo_en) begin
				rx_in_valid = 1'b1;
				if (!rx_in_ready) begin
					int_set[`INT_OVR_BIT] = 1'b1;
				end
			end else begin
				if (st.rx_hold_v && !(addr_ok && !hwrite && rd_sel == SEL_ALIAS)) begin
					int_set[`INT_OVR_BIT] = 1'b1;
				end
				next_st.rx_hold   = rx_byte;
				next_st.rx_hold_v = 1'b1;
			end
		end

		// Transmit start takes the head before a same-cycle write can replace it
		tx_start = !tx_busy && (st.fifo_en ? tx_out_valid : st.tx_hold_v);
		tx_pop   = tx_start && st.fifo_en;
		if (tx_start && !st.fifo_en) begin
			next_st.tx_hold_v = 1'b0;
		end
		if (tx_push) begin
			if (st.fifo_en) begin
				tx_in_valid = 1'b1;
			end else begin
				next_st.tx_hold   = hwdata[7:0];
				next_st.tx_hold_v = 1'b1;
			end
		end

		// Sticky events: a set in the same cycle as a write-one clear wins
		next_st.tx_holding_empty_d = tx_holding_empty;
		int_set[`INT_TX_HOLDING_EMPTY_BIT] = tx_holding_empty && !st.tx_holding_empty_d;
		if (int_set[`INT_OVR_BIT]) begin
			next_st.ovr = 1'b1;
		end
		if (st.wr_pend && wr_sel == SEL_ISTAT) begin
			next_st.int_stat = (st.int_stat & ~hwdata[2:0]) | int_set;
		end else begin
			next_st.int_stat = st.int_stat | int_set;
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st          <= '0;
			st.divisor  <= `DIVISOR_RESET;
			st.int_stat <= `INT_RESET;
			st.int_mask <= `INT_RESET;
			st.tx_holding_empty_d   <= 1'b1;
			st.rx_state <= LINE_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// FIFOs and serialiser
	// ****************************************
	byte_fifo u_rx_fifo (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.flush     (rx_flush),
		.in_valid  (rx_in_valid),
		.in_data   (rx_byte),
		.out_ready (rx_pop),
		.in_ready  (rx_in_ready),
		.out_valid (rx_out_valid),
		.out_data  (rx_head),
		.count     (rx_count)
	);

	byte_fifo u_tx_fifo (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.flush     (tx_flush),
		.in_valid  (tx_in_valid),
		.in_data   (hwdata[7:0]),
		.out_ready (tx_pop),
		.in_ready  (tx_in_ready),
		.out_valid (tx_out_valid),
		.out_data  (tx_head),
		.count     (tx_count)
	);

	serial_tx u_tx (
		.hclk    (hclk),
		.hresetn (hresetn),
		.divisor (st.divisor),
		.start   (tx_start),
		.data    (tx_byte),
		.busy    (tx_busy),
		.line    (tx_line)
	);

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Upper alias bits stand at zero for the whole data phase
	property p_alias_upper_zero;
		st.rd_alias |-> hrdata[31:8] == 24'h00_0000;
	endproperty
	a_alias_upper_zero: assert property (p_alias_upper_zero)
		else $error("alias read upper bits not zero");

	// Any of the sixteen aliases reads the head byte
	property p_alias_head;
		addr_ok && !hwrite && rd_sel == SEL_ALIAS && st.fifo_en && rx_out_valid
			|=> hrdata[7:0] == $past(rx_head) && st.rd_alias;
	endproperty
	a_alias_head: assert property (p_alias_head)
		else $error("alias read did not return fifo head");

	// Unread holding byte overwritten with overrun
	property p_hold_overrun;
		!st.fifo_en && rx_done && st.rx_hold_v && !rx_pop && !(addr_ok && !hwrite)
			|=> st.ovr && st.int_stat[`INT_OVR_BIT] && st.rx_hold == $past(rx_byte);
	endproperty
	a_hold_overrun: assert property (p_hold_overrun)
		else $error("overrun without fifo not flagged");

	// Full receive FIFO keeps its entries and drops the byte
	property p_fifo_overrun;
		st.fifo_en && rx_done && rx_count == `FIFO_DEPTH && !rx_pop && !rx_flush
			|=> rx_count == `FIFO_DEPTH && st.ovr && st.int_stat[`INT_OVR_BIT];
	endproperty
	a_fifo_overrun: assert property (p_fifo_overrun)
		else $error("full receive fifo overrun mishandled");

	// Data ready follows the stored byte
	property p_ready_after_rx;
		rx_done && !rx_flush && !(st.fifo_en && rx_count == `FIFO_DEPTH) |=> data_ready;
	endproperty
	a_ready_after_rx: assert property (p_ready_after_rx)
		else $error("data ready not set after reception");

	// One write without FIFO clears the holding-empty flag
	property p_tx_holding_empty_clear;
		!st.fifo_en && tx_holding_empty && tx_push |=> !tx_holding_empty;
	endproperty
	a_tx_holding_empty_clear: assert property (p_tx_holding_empty_clear)
		else $error("holding empty not cleared by write");

	// A second write replaces the pending byte
	property p_tx_overwrite;
		!st.fifo_en && !tx_holding_empty && tx_push && !tx_start |=> st.tx_hold == $past(hwdata[7:0]);
	endproperty
	a_tx_overwrite: assert property (p_tx_overwrite)
		else $error("pending transmit byte not overwritten");

	// Write to a full transmit FIFO is lost
	property p_tx_full_drop;
		st.fifo_en && tx_push && tx_count == `FIFO_DEPTH && !tx_pop && !tx_flush
			|=> tx_count == `FIFO_DEPTH;
	endproperty
	a_tx_full_drop: assert property (p_tx_full_drop)
		else $error("write to full transmit fifo changed it");

	// Accepted FIFO write grows the count by one
	property p_tx_fifo_accept;
		st.fifo_en && tx_push && tx_count < `FIFO_DEPTH && !tx_pop && !tx_flush
			|=> tx_count == $past(tx_count) + 5'h01;
	endproperty
	a_tx_fifo_accept: assert property (p_tx_fifo_accept)
		else $error("transmit fifo did not accept byte");

	// An idle serialiser starts the written byte within two cycles
	property p_tx_starts;
		tx_push && !tx_busy && tx_holding_empty && !tx_flush |=> ##[0:2] tx_busy;
	endproperty
	a_tx_starts: assert property (p_tx_starts)
		else $error("written byte not sent");

endmodule // shadow_data_port

`default_nettype wire

// ### hdl/shadow_port_defines.svh
// Register map, field positions and reset values of the shadow data port
`ifndef SHADOW_PORT_DEFINES_SVH
`define SHADOW_PORT_DEFINES_SVH

// ****************************************
// Address map
// ****************************************
`define ADDR_ALIAS_FIRST  32'h5000_1130
`define ADDR_ALIAS10      32'h5000_1158
`define ADDR_ALIAS11      32'h5000_115C
`define ADDR_ALIAS_LAST   32'h5000_116C
`define ADDR_FIFO_CTRL    32'h5000_1108
`define ADDR_LINE_STAT    32'h5000_1114
`define ADDR_MODE         32'h5000_1120
`define ADDR_DIVISOR      32'h5000_1124
`define ADDR_INT_STAT     32'h5000_1128
`define ADDR_INT_MASK     32'h5000_112C

// ****************************************
// Field positions
// ****************************************
`define FCR_EN_BIT        0
`define FCR_RXCLR_BIT     1
`define FCR_TXCLR_BIT     2
`define MODE_IR_BIT       0
`define LSR_DR_BIT        0
`define LSR_OVR_BIT       1
`define LSR_TX_HOLDING_EMPTY_BIT      5
`define LSR_TEMT_BIT      6
`define INT_RX_BIT        0
`define INT_OVR_BIT       1
`define INT_TX_HOLDING_EMPTY_BIT      2

// ****************************************
// Sizes and reset values
// ****************************************
`define FIFO_DEPTH        5'h10
`define DIVISOR_RESET     16'h0010
`define INT_RESET         3'h0
`define BYTE_RESET        8'h00

`endif

// ### hdl/shadow_port_pkg.sv
// Types and shared decode functions of the shadow data port
`include "shadow_port_defines.svh"

package shadow_port_pkg;

	// ****************************************
	// Enumerations
	// ****************************************
	typedef enum logic [1:0] {
		LINE_IDLE  = 2'b00,
		LINE_START = 2'b01,
		LINE_DATA  = 2'b10,
		LINE_STOP  = 2'b11
	} line_state_t;

	typedef enum logic [2:0] {
		SEL_NONE  = 3'b000,
		SEL_ALIAS = 3'b001,
		SEL_FCR   = 3'b010,
		SEL_LSR   = 3'b011,
		SEL_MODE  = 3'b100,
		SEL_DIV   = 3'b101,
		SEL_ISTAT = 3'b110,
		SEL_IMASK = 3'b111
	} reg_sel_t;

	// ****************************************
	// State records
	// ****************************************
	typedef struct packed {
		logic [15:0][7:0] mem;
		logic [3:0]       wr_ptr;
		logic [3:0]       rd_ptr;
		logic [4:0]       count;
	} fifo_regs_t;

	typedef struct packed {
		line_state_t state;
		logic [15:0] cnt;
		logic [2:0]  bitn;
		logic [7:0]  shreg;
		logic        line;
	} tx_regs_t;

	typedef struct packed {
		logic        wr_pend;
		logic [31:0] wr_addr;
		logic        rd_alias;
		logic [31:0] hrdata;
		logic        fifo_en;
		logic        ir_mode;
		logic [15:0] divisor;
		logic [2:0]  int_stat;
		logic [2:0]  int_mask;
		logic        ovr;
		logic        tx_holding_empty_d;
		logic [7:0]  rx_hold;
		logic        rx_hold_v;
		logic [7:0]  tx_hold;
		logic        tx_hold_v;
		line_state_t rx_state;
		logic [15:0] rx_cnt;
		logic [2:0]  rx_bit;
		logic [7:0]  rx_sh;
	} main_regs_t;

	// ****************************************
	// Functions
	// ****************************************
	// End of one bit time; a divisor of 0 or 1 means one cycle per bit
	function automatic logic last_tick(input logic [15:0] cnt, input logic [15:0] div);
		return (div <= 16'h0001) || (cnt >= div - 16'h0001);
	endfunction

	// Register decode, shared by the read and the write phase
	function automatic reg_sel_t reg_sel(input logic [31:0] addr);
		if (addr >= `ADDR_ALIAS_FIRST && addr <= `ADDR_ALIAS_LAST && addr[1:0] == 2'b00) begin
			return SEL_ALIAS;
		end else if (addr == `ADDR_FIFO_CTRL) begin
			return SEL_FCR;
		end else if (addr == `ADDR_LINE_STAT) begin
			return SEL_LSR;
		end else if (addr == `ADDR_MODE) begin
			return SEL_MODE;
		end else if (addr == `ADDR_DIVISOR) begin
			return SEL_DIV;
		end else if (addr == `ADDR_INT_STAT) begin
			return SEL_ISTAT;
		end else if (addr == `ADDR_INT_MASK) begin
			return SEL_IMASK;
		end else begin
			return SEL_NONE;
		end
	endfunction

endpackage

// ### hdl/byte_fifo.sv
// Sixteen-entry byte FIFO held in flip-flops
`timescale 1ns/100ps
`default_nettype none
`include "shadow_port_defines.svh"

module byte_fifo import shadow_port_pkg::*; (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       flush,
	input  wire logic       in_valid,
	input  wire logic [7:0] in_data,
	input  wire logic       out_ready,
	output logic            in_ready,
	output logic            out_valid,
	output logic [7:0]      out_data,
	output logic [4:0]      count
);

	fifo_regs_t st;
	fifo_regs_t next_st;
	logic       push;
	logic       pop;

	// A full FIFO still takes a byte when the head leaves in the same cycle
	assign out_valid = (st.count != 5'h00);
	assign in_ready  = (st.count != `FIFO_DEPTH) || out_ready;
	assign out_data  = st.mem[st.rd_ptr];
	assign count     = st.count;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointer and count update
	always_comb begin
		next_st = st;
		if (flush) begin
			next_st.wr_ptr = 4'h0;
			next_st.rd_ptr = 4'h0;
			next_st.count  = 5'h00;
		end else begin
			if (push) begin
				next_st.mem[st.wr_ptr] = in_data;
				next_st.wr_ptr = st.wr_ptr + 4'h1;
			end
			if (pop) begin
				next_st.rd_ptr = st.rd_ptr + 4'h1;
			end
			next_st.count = st.count + {4'h0, push} - {4'h0, pop};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule // byte_fifo

`default_nettype wire

// ### hdl/serial_tx.sv
// Serialiser: start bit, eight data bits LSB first, one stop bit
`timescale 1ns/100ps
`default_nettype none
`include "shadow_port_defines.svh"

module serial_tx import shadow_port_pkg::*; (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic [15:0] divisor,
	input  wire logic        start,
	input  wire logic [7:0]  data,
	output logic             busy,
	output logic             line
);

	tx_regs_t st;
	tx_regs_t next_st;

	assign busy = (st.state != LINE_IDLE);
	assign line = st.line;

	// Frame sequencer; start is ignored while a frame is on the line
	always_comb begin
		next_st = st;
		next_st.cnt = st.cnt + 16'h0001;
		case (st.state)
			LINE_IDLE: begin
				next_st.cnt  = 16'h0000;
				next_st.line = 1'b1;
				if (start) begin
					next_st.state = LINE_START;
					next_st.shreg = data;
					next_st.line  = 1'b0;
				end
			end
			LINE_START: begin
				if (last_tick(st.cnt, divisor)) begin
					next_st.cnt   = 16'h0000;
					next_st.state = LINE_DATA;
					next_st.bitn  = 3'h0;
					next_st.line  = st.shreg[0];
				end
			end
			LINE_DATA: begin
				if (last_tick(st.cnt, divisor)) begin
					next_st.cnt   = 16'h0000;
					next_st.shreg = {1'b1, st.shreg[7:1]};
					next_st.bitn  = st.bitn + 3'h1;
					next_st.line  = st.shreg[1];
					if (st.bitn == 3'h7) begin
						next_st.state = LINE_STOP;
						next_st.line  = 1'b1;
					end
				end
			end
			default: begin
				if (last_tick(st.cnt, divisor)) begin
					next_st.cnt   = 16'h0000;
					next_st.state = LINE_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '{state: LINE_IDLE, cnt: 16'h0000, bitn: 3'h0, shreg: `BYTE_RESET, line: 1'b1};
		end else begin
			st <= next_st;
		end
	end

endmodule // serial_tx

`default_nettype wire

// ### verification/remote_uart.sv
// Behavioural remote serial transceiver facing the shadow data port
`timescale 1ns/100ps
`default_nettype none

module remote_uart #(
	parameter int DIV = 4
) (
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic [7:0] byte_in,
	input  wire logic       line_in,
	output logic            line_out,
	output logic            busy,
	output logic            got,
	output logic [7:0]      got_byte
);
	logic [9:0] frame;
	logic [7:0] sh;

	// Sender: start bit, eight data bits low first, stop bit; line idles high
	initial begin
		line_out = 1'b1;
		busy = 1'b0;
		forever begin
			@(posedge clk);
			if (go) begin
				busy <= 1'b1;
				frame = {1'b1, byte_in, 1'b0};
				for (int i = 0; i < 10; i++) begin
					line_out <= frame[i];
					repeat (DIV) @(posedge clk);
				end
				busy <= 1'b0;
			end
		end
	end

	// Receiver: samples mid-bit, stop level not judged to stay tolerant
	initial begin
		got = 1'b0;
		got_byte = 8'h00;
		forever begin
			@(negedge line_in);
			repeat (DIV / 2) @(posedge clk);
			for (int i = 0; i < 8; i++) begin
				repeat (DIV) @(posedge clk);
				sh[i] = line_in;
			end
			repeat (DIV) @(posedge clk);
			got <= 1'b1;
			got_byte <= sh;
			@(posedge clk);
			got <= 1'b0;
		end
	end
endmodule // remote_uart
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench: bus master, remote transceiver and result checks
`timescale 1ns/100ps
`default_nettype none
`include "shadow_port_defines.svh"

module tb_top;
	logic             hclk, hresetn, hsel, hwrite, rd_chk, go, ir;
	logic [1:0]       htrans;
	logic [31:0]      haddr, hwdata, q;
	logic [7:0]       tx_b, v;
	wire logic        hready, hresp, sout, sir_out_n, irq, p_line, busy, got;
	wire logic [31:0] hrdata;
	wire logic [7:0]  got_byte;
	logic [31:0]      exp_rd[$], exp_tx[$], bytes[$];
	int               seed, n_errors, checks;

	shadow_data_port shadow_data_port_i (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
		.sin(ir ? 1'b1 : p_line), .sir_in(ir ? ~p_line : 1'b0), .sout(sout),
		.sir_out_n(sir_out_n), .irq(irq));

	remote_uart #(.DIV(4)) remote_uart_i (
		.clk(hclk), .go(go), .byte_in(tx_b), .line_in(ir ? sir_out_n : sout),
		.line_out(p_line), .busy(busy), .got(got), .got_byte(got_byte));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic end_of_test();
		if (exp_rd.size() != 0 || exp_tx.size() != 0) n_errors++;
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Bounded wait for hready; a hung slave ends the run
	task automatic to_ready();
		for (int k = 0; k < 40; k++) begin
			@(posedge hclk);
			if (hready === 1'b1) return;
		end
		n_errors++;
		end_of_test();
	endtask

	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input logic c);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		to_ready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		rd_chk <= c & ~w;
		to_ready();
		q = hrdata;
		rd_chk <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 1'b0);
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		exp_rd.push_back(e);
		xfer(1'b0, a, 32'h0000_0000, 1'b1);
	endtask

	// Partner sends one frame; its end lies past the device's stop sample
	task automatic send(input logic [7:0] d);
		@(posedge hclk);
		tx_b <= d;
		go <= 1'b1;
		@(posedge hclk);
		go <= 1'b0;
		for (int k = 0; k < 60; k++) begin
			@(posedge hclk);
			if (!busy) return;
		end
		n_errors++;
		end_of_test();
	endtask

	task automatic drain();
		for (int k = 0; k < 9000; k++) begin
			@(posedge hclk);
			if (exp_tx.size() == 0) return;
		end
		n_errors++;
		end_of_test();
	endtask

	task automatic chk_irq(input logic e);
		@(negedge hclk);
		cmp({30'h0000_0000, hresp, irq}, {30'h0000_0000, 1'b0, e});
	endtask

	// ****************************************
	// Clock and result monitor
	// ****************************************
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	// Oldest note is taken as each read or serial byte shows up
	always @(posedge hclk) begin
		if (rd_chk && hready) cmp(hrdata, exp_rd.pop_front());
		if (got) cmp({24'h00_0000, got_byte}, exp_tx.pop_front());
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		seed = 32'h0000_79be;
		{hsel, hwrite, rd_chk, go, ir, htrans, haddr, hwdata, tx_b} = '0;
		hresetn = 1'b0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		rd(`ADDR_ALIAS10, 32'h0000_0000);
		rd(`ADDR_LINE_STAT, 32'h0000_0060);
		rd(`ADDR_ALIAS_LAST + 32'h0000_0004, 32'h0000_0000);
		rd(`ADDR_ALIAS_FIRST + 32'h0000_0001, 32'h0000_0000);
		$display("reset test done");
		// Bit time of four cycles keeps frames short
		wr(`ADDR_DIVISOR, 32'h0000_0004);
		wr(`ADDR_INT_MASK, 32'h0000_0001);
		v = 8'($random(seed));
		send(v);
		chk_irq(1'b1);
		rd(`ADDR_ALIAS10, {24'h00_0000, v});
		wr(`ADDR_INT_STAT, 32'h0000_0007);
		chk_irq(1'b0);
		send(8'h3c);
		send(8'hc3);
		rd(`ADDR_INT_STAT, 32'h0000_0003);
		rd(`ADDR_LINE_STAT, 32'h0000_0063);
		rd(`ADDR_ALIAS_LAST, 32'h0000_00c3);
		rd(`ADDR_LINE_STAT, 32'h0000_0060);
		$display("receive without fifo test done");
		// Third write lands on the pending byte while the first shifts out
		v = 8'($random(seed));
		exp_tx.push_back({24'h00_0000, v});
		wr(`ADDR_ALIAS_FIRST, {24'hff_ffff, v});
		wr(`ADDR_ALIAS10, 32'ha5a5_a55a);
		rd(`ADDR_LINE_STAT, 32'h0000_0000);
		exp_tx.push_back(32'h0000_0081);
		wr(`ADDR_ALIAS11, 32'h0000_0081);
		drain();
		$display("transmit without fifo test done");
		wr(`ADDR_INT_MASK, 32'h0000_0000);
		wr(`ADDR_FIFO_CTRL, 32'h0000_0001);
		// Two bytes leave for the shifter while writing, sixteen fill, the last is lost
		for (int i = 0; i < 19; i++) begin
			v = 8'($random(seed));
			if (i < 18) exp_tx.push_back({24'h00_0000, v});
			wr(`ADDR_ALIAS_FIRST + 32'(4 * (i % 16)), {24'h00_0000, v});
		end
		rd(`ADDR_LINE_STAT, 32'h0000_0000);
		drain();
		$display("transmit fifo test done");
		for (int i = 0; i < 17; i++) begin
			v = 8'($random(seed));
			bytes.push_back({24'h00_0000, v});
			send(v);
		end
		chk_irq(1'b0);
		rd(`ADDR_LINE_STAT, 32'h0000_0063);
		for (int i = 0; i < 16; i++) begin
			rd(`ADDR_ALIAS_FIRST + 32'(4 * i), bytes[i]);
		end
		rd(`ADDR_LINE_STAT, 32'h0000_0060);
		$display("receive fifo test done");
		wr(`ADDR_MODE, 32'h0000_0001);
		@(posedge hclk);
		ir <= 1'b1;
		v = 8'($random(seed));
		send(v);
		rd(`ADDR_ALIAS11, {24'h00_0000, v});
		v = 8'($random(seed));
		exp_tx.push_back({24'h00_0000, v});
		wr(`ADDR_ALIAS10, {24'h00_0000, v});
		drain();
		$display("infrared test done");
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
